// *** atg_trigger_gate.sv ***
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - software source: init write issues a converter start pulse
// - software source: conversion begins at once, no external condition
// - work pulses repeat with period set by the sampling divisor
// - external source: hold off conversion until trigger condition met
// - external trigger comes only from the trigger input pin
// - trigger kind selects edge or level operation
// - edge, negative: falling transition starts conversion
// - edge, positive: rising transition starts conversion
// - edge, both: any transition starts conversion
// - after edge start, later trigger changes ignored until acquisition ends
// - level, negative: convert only while trigger low
// - level, positive: convert only while trigger high
// - level, both: behaves as software start source
// - general purpose outputs are low after power-on
module atg_trigger_gate #(
   parameter int DIV_WIDTH = 32,
   parameter int GPIO_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic triggerIn,
   input wire logic [GPIO_WIDTH-1:0] gpInputs,
   output logic [GPIO_WIDTH-1:0] gpOutputs,
   output logic convStart,
   output logic convPulse,
   output logic convActive
);
   // ********************************************************************
   // settings registers
   // ********************************************************************
   logic startSourceSelect_ff;
   logic triggerKindSelect_ff;
   logic [1:0] triggerPolaritySelect_ff;
   logic [DIV_WIDTH-1:0] divisor_ff;
   logic [GPIO_WIDTH-1:0] gpOut_ff;
   logic [31:0] pulseCount_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic convStart_ff;
   logic convPulse_ff;
   logic convActive_ff;
   localparam int SYNC_STAGES_W = atg_pkg::SYNC_STAGES;
   logic [SYNC_STAGES_W-1:0] trigSync_ff;
   logic trigPrev_ff;
   atg_pkg::atg_state_e state_ff;
   atg_pkg::atg_state_e nxt_state;

   // ********************************************************************
   // apb decode
   // ********************************************************************
   wire logic setup = psel && !penable;
   wire logic wrAccess = psel && penable && pwrite && pready_ff;
   wire logic hitCtrl = paddr == atg_pkg::ADDR_CTRL;
   wire logic hitDiv = paddr == atg_pkg::ADDR_DIVISOR;
   wire logic hitStat = paddr == atg_pkg::ADDR_STATUS;
   wire logic hitGpOut = paddr == atg_pkg::ADDR_GPOUT;
   wire logic hitGpIn = paddr == atg_pkg::ADDR_GPIN;
   wire logic hitCnt = paddr == atg_pkg::ADDR_PULSECNT;
   wire logic mapped = hitCtrl || hitDiv || hitStat || hitGpOut || hitGpIn || hitCnt;
   wire logic wrCtrl = wrAccess && hitCtrl;
   wire logic startCmd = wrCtrl && pwdata[atg_pkg::CTRL_START_BIT];
   wire logic stopCmd = wrCtrl && pwdata[atg_pkg::CTRL_STOP_BIT];
   // settings are taken only while idle, so a run keeps its mode
   wire logic cfgWrite = wrCtrl && (state_ff == atg_pkg::ATG_IDLE);

   wire logic [31:0] ctrlView = {26'h000_0000, triggerPolaritySelect_ff,
      triggerKindSelect_ff, startSourceSelect_ff, 2'h0};
   wire logic [31:0] statView = {29'h0000_0000, trigSync_ff[SYNC_STAGES_W-1],
      convActive_ff, state_ff != atg_pkg::ATG_IDLE};
   wire logic [31:0] rdMux = hitCtrl ? ctrlView :
      hitDiv ? 32'(divisor_ff) :
      hitStat ? statView :
      hitGpOut ? 32'(gpOut_ff) :
      hitGpIn ? 32'(gpInputs) :
      hitCnt ? pulseCount_ff : 32'h0000_0000;

   // ********************************************************************
   // trigger synchroniser and detection
   // ********************************************************************
   // only the last stage is looked at; the first may be metastable
   wire logic trig = trigSync_ff[SYNC_STAGES_W-1];
   wire logic rise = trig && !trigPrev_ff;
   wire logic fall = !trig && trigPrev_ff;
   wire logic edgeHit = (triggerPolaritySelect_ff == atg_pkg::POLARITY_NEGATIVE) ? fall :
      (triggerPolaritySelect_ff == atg_pkg::POLARITY_POSITIVE) ? rise :
      (rise || fall);
   wire logic levelOk = (triggerPolaritySelect_ff == atg_pkg::POLARITY_NEGATIVE) ? !trig :
      (triggerPolaritySelect_ff == atg_pkg::POLARITY_POSITIVE) ? trig :
      1'b1;
   wire logic isLevel = triggerKindSelect_ff == atg_pkg::KIND_LEVEL;
   wire logic softLike = (startSourceSelect_ff == atg_pkg::START_SOURCE_SOFTWARE) ||
      (isLevel && triggerPolaritySelect_ff == atg_pkg::POLARITY_BOTH);

   // ********************************************************************
   // sequencer
   // ********************************************************************
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         atg_pkg::ATG_IDLE: begin
            if (startCmd) begin
               nxt_state = softLike ? atg_pkg::ATG_RUN : atg_pkg::ATG_ARMED;
            end
         end
         atg_pkg::ATG_ARMED: begin
            if (stopCmd) begin
               nxt_state = atg_pkg::ATG_IDLE;
            end else if (isLevel ? levelOk : edgeHit) begin
               // level runs also wait for the pin, so the start pulse meets an open gate
               nxt_state = atg_pkg::ATG_RUN;
            end
         end
         atg_pkg::ATG_RUN: begin
            if (stopCmd) begin
               nxt_state = atg_pkg::ATG_IDLE;
            end
         end
         default: nxt_state = atg_pkg::ATG_IDLE;
      endcase
   end

   // edge runs ignore the pin once started; level runs gate on it unless the polarity is both or the source is software
   wire logic nxtActive = (nxt_state == atg_pkg::ATG_RUN) &&
      (softLike || !isLevel || levelOk);
   wire logic runEntry = (nxt_state == atg_pkg::ATG_RUN) && (state_ff != atg_pkg::ATG_RUN);
   wire logic tick;

   atg_pulse_gen #(
      .WIDTH(DIV_WIDTH)
   ) u_pulse (
      .mclk(mclk),
      .resetn(resetn),
      .enable(nxtActive),
      .restart(nxtActive && (runEntry || !convActive_ff)),
      .divisor(divisor_ff),
      .tick(tick)
   );

   // ********************************************************************
   // state and settings
   // ********************************************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= atg_pkg::ATG_IDLE;
         trigSync_ff <= '0;
         trigPrev_ff <= 1'b0;
         convStart_ff <= 1'b0;
         convActive_ff <= 1'b0;
         convPulse_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         trigSync_ff <= {trigSync_ff[SYNC_STAGES_W-2:0], triggerIn};
         trigPrev_ff <= trig;
         convStart_ff <= runEntry;
         convActive_ff <= nxtActive;
         convPulse_ff <= tick && convActive_ff;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         startSourceSelect_ff <= atg_pkg::START_SOURCE_SOFTWARE;
         triggerKindSelect_ff <= atg_pkg::KIND_EDGE;
         triggerPolaritySelect_ff <= atg_pkg::POLARITY_NEGATIVE;
         divisor_ff <= DIV_WIDTH'(atg_pkg::DIVISOR_RESET);
         gpOut_ff <= GPIO_WIDTH'(atg_pkg::GPOUT_RESET);
      end else begin
         if (cfgWrite) begin
            startSourceSelect_ff <= pwdata[atg_pkg::CTRL_SRC_BIT];
            triggerKindSelect_ff <= pwdata[atg_pkg::CTRL_KIND_BIT];
            triggerPolaritySelect_ff <= pwdata[atg_pkg::CTRL_POL_LSB+:2];
         end
         if (wrAccess && hitDiv && state_ff == atg_pkg::ATG_IDLE) begin
            divisor_ff <= pwdata[DIV_WIDTH-1:0];
         end
         if (wrAccess && hitGpOut) begin
            gpOut_ff <= pwdata[GPIO_WIDTH-1:0];
         end
      end
   end

   // ********************************************************************
   // apb answer: no wait state, read data valid with pready
   // ********************************************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         pulseCount_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup && !mapped;
         prdata_ff <= (setup && !pwrite) ? rdMux : 32'h0000_0000;
         if (runEntry) begin
            pulseCount_ff <= 32'h0000_0000;
         end else if (convPulse_ff) begin
            pulseCount_ff <= pulseCount_ff + 32'h0000_0001;
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign gpOutputs = gpOut_ff;
   assign convStart = convStart_ff;
   assign convPulse = convPulse_ff;
   assign convActive = convActive_ff;
endmodule // atg_trigger_gate

// *** atg_pkg.sv ***
package atg_pkg;
   // ********************************************************************
   // register map (byte addresses)
   // ********************************************************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_DIVISOR = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_GPOUT = 12'h00C;
   localparam logic [11:0] ADDR_GPIN = 12'h010;
   localparam logic [11:0] ADDR_PULSECNT = 12'h014;

   // ********************************************************************
   // control field positions
   // ********************************************************************
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_SRC_BIT = 2;
   localparam int CTRL_KIND_BIT = 3;
   localparam int CTRL_POL_LSB = 4;

   // ********************************************************************
   // settings and reset values
   // ********************************************************************
   localparam logic START_SOURCE_SOFTWARE = 1'b0;
   localparam logic START_SOURCE_EXTERNAL = 1'b1;
   localparam logic KIND_EDGE = 1'b0;
   localparam logic KIND_LEVEL = 1'b1;
   localparam logic [1:0] POLARITY_NEGATIVE = 2'h0;
   localparam logic [1:0] POLARITY_POSITIVE = 2'h1;
   localparam logic [1:0] POLARITY_BOTH = 2'h2;

   localparam logic [31:0] DIVISOR_RESET = 32'h0000_01F4;
   localparam logic [15:0] GPOUT_RESET = 16'h0000;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      ATG_IDLE,
      ATG_ARMED,
      ATG_RUN
   } atg_state_e;
endpackage

// *** atg_pulse_gen.sv ***
`timescale 1ns/1ps
// ***********************************************************************
// periodic work pulse divider
// ***********************************************************************
module atg_pulse_gen #(
   parameter int WIDTH = 32
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic enable,
   input wire logic restart,
   input wire logic [WIDTH-1:0] divisor,
   output logic tick
);
   logic [WIDTH-1:0] count_ff;
   logic tick_ff;
   wire logic atTerm = (count_ff >= divisor - WIDTH'(1)) || (divisor == '0);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_ff <= '0;
         tick_ff <= 1'b0;
      end else if (restart || !enable) begin
         // first pulse of a run comes out at once, later ones every divisor cycles
         count_ff <= '0;
         tick_ff <= restart;
      end else begin
         count_ff <= atTerm ? '0 : count_ff + WIDTH'(1);
         tick_ff <= atTerm;
      end
   end

   assign tick = tick_ff;
endmodule // atg_pulse_gen

// *** atg_trigger_gate_sva.sv ***
`timescale 1ns/1ps
// *****
// port checks
// *****
module atg_trigger_gate_sva #(
   parameter int GPIO_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [GPIO_WIDTH-1:0] gpOutputs,
   input wire logic convStart,
   input wire logic convPulse,
   input wire logic convActive
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_ready_acc; pready |-> psel && penable; endproperty
   a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_rdz; !pready |-> prdata == 32'h0000_0000; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside access");
   property p_start_gate; convStart |-> convActive; endproperty
   a_start_gate: assert property (p_start_gate) else $error("start without gate");
   property p_start_once; convStart |=> !convStart [*4]; endproperty
   a_start_once: assert property (p_start_once) else $error("start repeated");
   // registered pulse may trail the gate by one cycle when level mode closes it
   property p_pulse; convPulse |-> convActive || $past(convActive); endproperty
   a_pulse: assert property (p_pulse) else $error("pulse with gate shut");
   property p_gpo; $rose(resetn) |-> gpOutputs == '0; endproperty
   a_gpo: assert property (p_gpo) else $error("outputs not low after reset");
endmodule // atg_trigger_gate_sva

bind atg_trigger_gate atg_trigger_gate_sva #(.GPIO_WIDTH(GPIO_WIDTH)) u_atg_trigger_gate_sva (
   .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .gpOutputs(gpOutputs), .convStart(convStart),
   .convPulse(convPulse), .convActive(convActive));

// *** atg_trig_src.sv ***
`timescale 1ns/1ps
// *****
// external trigger source, changes only just after a rising edge
// *****
module atg_trig_src (
   input wire logic mclk,
   output logic triggerIn
);
   initial triggerIn = 1'b0;
   task automatic drive(input logic v, input int dly);
      repeat (dly) @(posedge mclk);
      triggerIn <= v;
   endtask
endmodule // atg_trig_src

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
   logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, g;
   logic pready, pslverr, triggerIn, convStart, convPulse, convActive;
   logic [15:0] gpInputs = 0, gpOutputs;
   int num_errors = 0, n_compared = 0, cyc = 0, starts = 0, d, s;
   logic [31:0] mdl[int];
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (convStart === 1'b1) starts <= starts + 1;
      if (cyc == 6000) begin
         num_errors++;
         results();
      end
   end
   atg_trigger_gate u_atg_trigger_gate (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .triggerIn(triggerIn), .gpInputs(gpInputs),
      .gpOutputs(gpOutputs), .convStart(convStart), .convPulse(convPulse),
      .convActive(convActive));
   atg_trig_src u_atg_trig_src (.mclk(mclk), .triggerIn(triggerIn));
   // *****
   // tasks
   // *****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic e);
      int n;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 0;
      @(posedge mclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t apb access timed out", $time);
      end
      g = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic e;
      apb(1, a, wd, e);
      mdl[a] = wd;
   endtask
   task automatic rd(input logic [11:0] a, input logic err);
      logic e;
      apb(0, a, 0, e);
      chk(g, mdl.exists(a) ? mdl[a] : 32'h0000_0000);
      chk(e, err);
   endtask
   task automatic waitact(input logic want, input int lim);
      int n = 0;
      while (convActive !== want && n < lim) begin
         @(posedge mclk);
         n++;
      end
      chk(convActive, want);
   endtask
   function automatic logic [31:0] cw(input logic src, input logic kind, input logic [1:0] pol);
      return {26'h0, pol, kind, src, 2'b00};
   endfunction
   task automatic go(input logic [31:0] c);
      wr(atg_pkg::ADDR_CTRL, c);
      wr(atg_pkg::ADDR_CTRL, c | 32'h0000_0001);
      mdl[atg_pkg::ADDR_CTRL] = c;
   endtask
   task automatic results();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // *****
   // main sequence
   // *****
   initial begin
      void'($urandom(41));
      mdl[atg_pkg::ADDR_DIVISOR] = atg_pkg::DIVISOR_RESET;
      mdl[atg_pkg::ADDR_GPOUT] = 0;
      repeat (3) @(posedge mclk);
      resetn <= 1;
      @(posedge mclk);
      rd(atg_pkg::ADDR_GPOUT, 0);
      rd(atg_pkg::ADDR_DIVISOR, 0);
      rd(12'h0FC, 1);
      wr(atg_pkg::ADDR_GPOUT, $urandom & 32'h0000_FFFF);
      rd(atg_pkg::ADDR_GPOUT, 0);
      chk(gpOutputs, mdl[atg_pkg::ADDR_GPOUT]);
      gpInputs <= 16'($urandom);
      repeat (3) @(posedge mclk);
      mdl[atg_pkg::ADDR_GPIN] = gpInputs;
      rd(atg_pkg::ADDR_GPIN, 0);
      $display("test registers done");
      d = 3 + $urandom % 6;
      wr(atg_pkg::ADDR_DIVISOR, d);
      s = starts;
      go(cw(0, 0, 0));
      waitact(1, 4);
      @(posedge mclk);
      chk(starts, s + 1);
      begin
         automatic int n = 0;
         while (convPulse !== 1'b1 && n < 99) begin @(posedge mclk); n++; end
         n = 0;
         do begin @(posedge mclk); n++; end while (convPulse !== 1'b1 && n < 99);
         chk(n, d);
      end
      rd(atg_pkg::ADDR_CTRL, 0);
      wr(atg_pkg::ADDR_CTRL, 32'h0000_0002);
      waitact(0, 4);
      $display("test software start done");
      for (int p = 0; p < 3; p++) begin
         automatic logic idle = (p == 0);
         u_atg_trig_src.drive(idle, 1);
         s = starts;
         go(cw(1, 0, p[1:0]));
         repeat (10) @(posedge mclk);
         chk(convActive, 0);
         u_atg_trig_src.drive(!idle, 1 + $urandom % 3);
         waitact(1, 8);
         u_atg_trig_src.drive(idle, 2);
         repeat (8) @(posedge mclk);
         chk(convActive, 1);
         chk(starts, s + 1);
         wr(atg_pkg::ADDR_CTRL, 32'h0000_0002);
         waitact(0, 4);
      end
      $display("test edge modes done");
      for (int p = 0; p < 2; p++) begin
         automatic logic act = p[0];
         u_atg_trig_src.drive(!act, 1);
         go(cw(1, 1, p[1:0]));
         repeat (10) @(posedge mclk);
         chk(convActive, 0);
         u_atg_trig_src.drive(act, 1 + $urandom % 3);
         waitact(1, 8);
         u_atg_trig_src.drive(!act, 1);
         waitact(0, 8);
         u_atg_trig_src.drive(act, 1);
         waitact(1, 8);
         wr(atg_pkg::ADDR_CTRL, 32'h0000_0002);
         waitact(0, 4);
      end
      u_atg_trig_src.drive(0, 1);
      go(cw(1, 1, 2'h2));
      waitact(1, 4);
      $display("test level modes done");
      results();
   end
endmodule // tb
